// ===== design/acq_seq_map.vh
// Functional notes
// - Acquisition wait status can drive any one of output lines 1 to 4.
// - Accepted acquisition start trigger raises an acquisition-start event.
// - Accepted frame start trigger raises a frame-start event.
// - End of every exposure raises an exposure-end event.
// - Trigger pin is frame start in standard mode, acquisition start in legacy.
// - Exposure begins a fixed start delay after the trigger rising edge.
// - Start delay is a model constant, default 23.64 us.
// - With debouncing on, delay is start delay plus debounce time.
// - After exposure time elapses, sensor readout into the frame buffer starts.
// - Transmission starts only once enough lines are buffered.
// - Readout lasts (AOI height + 1) times line time plus fixed overhead.
// - Transmission time is never shorter than readout time.
// - With averaging, only one averaged image per acquisition is sent.
// - Readout-to-transmission delay varies with network readiness.
// - Wait status high while waiting for acquisition start, low after.
// - Acquisition start trigger outside waiting is ignored, overtrigger reported.
`ifndef ACQ_SEQ_MAP_VH
`define ACQ_SEQ_MAP_VH

`define ADDR_CTRL        8'h00
`define ADDR_LINE_SEL    8'h04
`define ADDR_LINE_SRC    8'h08
`define ADDR_DEBOUNCE    8'h0c
`define ADDR_AOI_HEIGHT  8'h10
`define ADDR_TX_TIME     8'h14
`define ADDR_EXPOSURE    8'h18
`define ADDR_FRAME_COUNT 8'h1c
`define ADDR_TX_THRESH   8'h20
`define ADDR_STATUS      8'h24
`define ADDR_EVT_STATUS  8'h28
`define ADDR_EVT_MASK    8'h2c
`define ADDR_CMD         8'h30

`define CTRL_LEGACY      0
`define CTRL_AVG         1
`define CTRL_DEB         2
`define CMD_ACQ_START    0
`define CMD_ACQ_STOP     1

`define EVT_ACQ_START    0
`define EVT_FRAME_START  1
`define EVT_EXP_END      2
`define EVT_ACQ_OVER     3
`define EVT_FRAME_OVER   4
`define EVT_W            5

`define SRC_LOW          2'h0
`define SRC_ACQ_WAIT     2'h1
`define SRC_EXP_ACTIVE   2'h2
`define SRC_TX_ACTIVE    2'h3

`define STAT_LINES_LSB   16

`define RST_EXPOSURE     24'h000fa0
`define RST_AOI_HEIGHT   12'h0f0
`define RST_TX_THRESH    12'h010
`define RST_FRAME_COUNT  8'h01

`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`define CLK_MHZ          20
`define START_DELAY_NS   23640
`define LINE_TIME_NS     8760
`define OVERHEAD_NS      511570
`define START_DELAY_CYC  ((`START_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define LINE_CYC         ((`LINE_TIME_NS * `CLK_MHZ + 999) / 1000)
`define OVERHEAD_CYC     ((`OVERHEAD_NS * `CLK_MHZ + 999) / 1000)

`endif

// ===== design/frame_acquisition_sequencer.v
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "acq_seq_map.vh"
module frame_acquisition_sequencer #(
  parameter [31:0] START_DELAY_CYC = `START_DELAY_CYC,
  parameter [31:0] LINE_CYC        = `LINE_CYC,
  parameter [31:0] OVERHEAD_CYC    = `OVERHEAD_CYC
)(
  input  wire        I_CORE_CLK,
  input  wire        I_NRST,
  input  wire        I_AWVALID,
  output wire        O_AWREADY,
  input  wire [7:0]  I_AWADDR,
  input  wire        I_WVALID,
  output wire        O_WREADY,
  input  wire [31:0] I_WDATA,
  input  wire [3:0]  I_WSTRB,
  output wire        O_BVALID,
  input  wire        I_BREADY,
  output wire [1:0]  O_BRESP,
  input  wire        I_ARVALID,
  output wire        O_ARREADY,
  input  wire [7:0]  I_ARADDR,
  output wire        O_RVALID,
  input  wire        I_RREADY,
  output wire [31:0] O_RDATA,
  output wire [1:0]  O_RRESP,
  input  wire        I_EXT_TRIGGER_IN,
  input  wire        I_NET_READY,
  output wire [3:0]  O_OUTPUT_LINE,
  output wire        O_EXPOSURE_ACTIVE,
  output wire        O_READOUT_ACTIVE,
  output wire        O_TX_ACTIVE,
  output wire        O_IRQ
);

  localparam [1:0] A_WAIT    = 2'b01;
  localparam [1:0] A_RUN     = 2'b10;
  localparam [3:0] F_IDLE    = 4'b0001;
  localparam [3:0] F_DELAY   = 4'b0010;
  localparam [3:0] F_EXPOSE  = 4'b0100;
  localparam [3:0] F_READOUT = 4'b1000;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          merge[k*8 +: 8] = data[k*8 +: 8];
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = ({a[7:2], 2'b00} <= `ADDR_CMD);
    end
  endfunction

  function [31:0] readout_cycles;
    input [11:0] h;
    begin
      readout_cycles = ({20'h00000, h} + 32'h1) * LINE_CYC + OVERHEAD_CYC;
    end
  endfunction

  reg        awready_reg;
  reg        arready_reg;
  reg        bvalid_reg;
  reg [1:0]  bresp_reg;
  reg        rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0]  rresp_reg;
  reg [2:0]  ctrl_reg;
  reg [1:0]  line_sel_reg;
  reg [1:0]  line_src_reg [0:3];
  reg [15:0] deb_time_reg;
  reg [11:0] aoi_height_reg;
  reg [23:0] tx_time_reg;
  reg [23:0] exposure_reg;
  reg [7:0]  frame_count_reg;
  reg [11:0] tx_thresh_reg;
  reg [`EVT_W-1:0] evt_status_reg;
  reg [`EVT_W-1:0] evt_mask_reg;
  reg        irq_reg;
  reg [3:0]  line_out_reg;

  reg        trig_s1_reg;
  reg        trig_s2_reg;
  reg        trig_prev_reg;
  reg        deb_busy_reg;
  reg [15:0] deb_cnt_reg;
  reg [1:0]  acq_state_reg;
  reg [7:0]  frames_left_reg;
  reg [3:0]  frame_state_reg;
  reg [31:0] frame_cnt_reg;
  reg [31:0] line_cnt_reg;
  reg [11:0] lines_done_reg;
  reg        tx_pend_reg;
  reg        avg_ready_reg;
  reg        tx_busy_reg;
  reg [31:0] tx_cnt_reg;

  integer i;

  wire [7:0]  waddr    = {I_AWADDR[7:2], 2'b00};
  wire [7:0]  raddr    = {I_ARADDR[7:2], 2'b00};
  // Ready is raised only when both channels wait, so the write lands once
  wire        wr_go    = awready_reg;
  wire [31:0] wr_bits  = merge(32'h0, I_WDATA, I_WSTRB);
  wire [31:0] wr_mask  = {{8{I_WSTRB[3]}}, {8{I_WSTRB[2]}},
                          {8{I_WSTRB[1]}}, {8{I_WSTRB[0]}}};
  wire        legacy   = ctrl_reg[`CTRL_LEGACY];
  wire        avg_en   = ctrl_reg[`CTRL_AVG];
  wire        cmd_start = wr_go && waddr == `ADDR_CMD && wr_bits[`CMD_ACQ_START];
  wire        cmd_stop  = wr_go && waddr == `ADDR_CMD && wr_bits[`CMD_ACQ_STOP];
  wire        trig_rise = trig_s2_reg & ~trig_prev_reg;
  wire        acq_wait  = acq_state_reg == A_WAIT;
  wire [31:0] rd_total  = readout_cycles(aoi_height_reg);
  wire [31:0] tx_eff    = ({8'h00, tx_time_reg} > rd_total) ?
                          {8'h00, tx_time_reg} : rd_total;
  wire        rd_last   = frame_state_reg == F_READOUT &&
                          frame_cnt_reg >= rd_total - 32'h1;

  reg         trig_qual;
  reg         acq_trig;
  reg         frame_trig;
  reg         frame_ok;
  reg         tx_go;
  reg [`EVT_W-1:0] evt;

  always @*
  begin
    trig_qual = 1'b0;
    if (!ctrl_reg[`CTRL_DEB] || deb_time_reg == 16'h0)
      trig_qual = trig_rise;
    else if (deb_busy_reg && trig_s2_reg &&
             deb_cnt_reg == deb_time_reg - 16'h1)
      trig_qual = 1'b1;
  end

  always @*
  begin
    acq_trig   = legacy ? trig_qual : cmd_start;
    frame_trig = legacy ? (acq_trig & acq_wait) : trig_qual;
    // Buffer holds one frame: a trigger is refused until the last frame starts to leave
    frame_ok   = frame_trig && frame_state_reg == F_IDLE && !tx_pend_reg &&
                 !avg_ready_reg && (legacy || acq_state_reg == A_RUN);
    // A threshold above the frame height still lets the finished frame go
    tx_go      = !tx_busy_reg && I_NET_READY &&
                 ((tx_pend_reg && (lines_done_reg >= tx_thresh_reg ||
                                   frame_state_reg == F_IDLE)) ||
                  avg_ready_reg);
    evt = {`EVT_W{1'b0}};
    evt[`EVT_ACQ_START]   = acq_trig & acq_wait;
    evt[`EVT_ACQ_OVER]    = acq_trig & ~acq_wait;
    evt[`EVT_FRAME_START] = frame_ok;
    evt[`EVT_FRAME_OVER]  = frame_trig & ~frame_ok;
    // Written this way a zero exposure still ends after one cycle
    evt[`EVT_EXP_END]     = frame_state_reg == F_EXPOSE &&
                            frame_cnt_reg + 32'h1 >= {8'h00, exposure_reg};
  end

  always @(posedge I_CORE_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      trig_s1_reg   <= 1'b0;
      trig_s2_reg   <= 1'b0;
      trig_prev_reg <= 1'b0;
      deb_busy_reg  <= 1'b0;
      deb_cnt_reg   <= 16'h0;
    end
    else
    begin
      trig_s1_reg   <= I_EXT_TRIGGER_IN;
      trig_s2_reg   <= trig_s1_reg;
      trig_prev_reg <= trig_s2_reg;
      // A pulse shorter than the debounce time is dropped
      if (trig_rise)
      begin
        deb_busy_reg <= 1'b1;
        deb_cnt_reg  <= 16'h0;
      end
      else if (!trig_s2_reg || trig_qual)
        deb_busy_reg <= 1'b0;
      else if (deb_busy_reg)
        deb_cnt_reg <= deb_cnt_reg + 16'h1;
    end
  end

  always @(posedge I_CORE_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      acq_state_reg   <= A_WAIT;
      frames_left_reg <= 8'h0;
      frame_state_reg <= F_IDLE;
      frame_cnt_reg   <= 32'h0;
      line_cnt_reg    <= 32'h0;
      lines_done_reg  <= 12'h0;
      tx_pend_reg     <= 1'b0;
      avg_ready_reg   <= 1'b0;
      tx_busy_reg     <= 1'b0;
      tx_cnt_reg      <= 32'h0;
    end
    else
    begin
      case (acq_state_reg)
        A_WAIT:
          if (acq_trig)
          begin
            acq_state_reg   <= A_RUN;
            // A legacy start carries its own single frame
            frames_left_reg <= legacy ? 8'h0 : frame_count_reg;
          end
        A_RUN:
          if (cmd_stop || (rd_last && frames_left_reg == 8'h0) ||
              frames_left_reg == 8'h0 && frame_state_reg == F_IDLE)
            acq_state_reg <= A_WAIT;
        default:
          acq_state_reg <= A_WAIT;
      endcase
      if (frame_ok && frames_left_reg != 8'h0)
        frames_left_reg <= frames_left_reg - 8'h1;

      frame_cnt_reg <= frame_cnt_reg + 32'h1;
      case (frame_state_reg)
        F_IDLE:
          if (frame_ok)
          begin
            frame_state_reg <= F_DELAY;
            frame_cnt_reg   <= 32'h0;
          end
        F_DELAY:
          if (frame_cnt_reg >= START_DELAY_CYC - 32'h1)
          begin
            frame_state_reg <= F_EXPOSE;
            frame_cnt_reg   <= 32'h0;
          end
        F_EXPOSE:
          if (evt[`EVT_EXP_END])
          begin
            frame_state_reg <= F_READOUT;
            frame_cnt_reg   <= 32'h0;
            line_cnt_reg    <= 32'h0;
            lines_done_reg  <= 12'h0;
            tx_pend_reg     <= !avg_en;
          end
        F_READOUT:
        begin
          line_cnt_reg <= line_cnt_reg + 32'h1;
          if (line_cnt_reg >= LINE_CYC - 32'h1)
          begin
            line_cnt_reg <= 32'h0;
            if (lines_done_reg <= aoi_height_reg)
              lines_done_reg <= lines_done_reg + 12'h1;
          end
          if (rd_last)
          begin
            frame_state_reg <= F_IDLE;
            if (avg_en && (frames_left_reg == 8'h0 || legacy))
              avg_ready_reg <= 1'b1;
          end
        end
        default:
          frame_state_reg <= F_IDLE;
      endcase

      if (tx_go)
      begin
        tx_busy_reg   <= 1'b1;
        tx_cnt_reg    <= 32'h0;
        tx_pend_reg   <= 1'b0;
        avg_ready_reg <= 1'b0;
      end
      else if (tx_busy_reg)
      begin
        tx_cnt_reg <= tx_cnt_reg + 32'h1;
        if (tx_cnt_reg >= tx_eff - 32'h1)
          tx_busy_reg <= 1'b0;
      end
    end
  end

  always @(posedge I_CORE_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      awready_reg     <= 1'b0;
      bvalid_reg      <= 1'b0;
      bresp_reg       <= `RESP_OKAY;
      ctrl_reg        <= 3'h0;
      line_sel_reg    <= 2'h0;
      deb_time_reg    <= 16'h0;
      aoi_height_reg  <= `RST_AOI_HEIGHT;
      tx_time_reg     <= 24'h0;
      exposure_reg    <= `RST_EXPOSURE;
      frame_count_reg <= `RST_FRAME_COUNT;
      tx_thresh_reg   <= `RST_TX_THRESH;
      evt_status_reg  <= {`EVT_W{1'b0}};
      evt_mask_reg    <= {`EVT_W{1'b0}};
      irq_reg         <= 1'b0;
      line_out_reg    <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
        line_src_reg[i] <= `SRC_LOW;
    end
    else
    begin
      awready_reg <= I_AWVALID && I_WVALID && !awready_reg && !bvalid_reg;
      if (wr_go)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= mapped(I_AWADDR) ? `RESP_OKAY : `RESP_SLVERR;
        case (waddr)
          `ADDR_CTRL:
            ctrl_reg <= wr_bits[2:0] | (ctrl_reg & ~wr_mask[2:0]);
          `ADDR_LINE_SEL:
            line_sel_reg <= wr_bits[1:0] | (line_sel_reg & ~{2{I_WSTRB[0]}});
          `ADDR_LINE_SRC:
            if (I_WSTRB[0])
              line_src_reg[line_sel_reg] <= I_WDATA[1:0];
          `ADDR_DEBOUNCE:
            deb_time_reg <= wr_bits[15:0] | (deb_time_reg & ~wr_mask[15:0]);
          `ADDR_AOI_HEIGHT:
            aoi_height_reg <= wr_bits[11:0] |
                              (aoi_height_reg & ~wr_mask[11:0]);
          `ADDR_TX_TIME:
            tx_time_reg <= wr_bits[23:0] | (tx_time_reg & ~wr_mask[23:0]);
          `ADDR_EXPOSURE:
            exposure_reg <= wr_bits[23:0] | (exposure_reg & ~wr_mask[23:0]);
          `ADDR_FRAME_COUNT:
            frame_count_reg <= wr_bits[7:0] |
                               (frame_count_reg & ~{8{I_WSTRB[0]}});
          `ADDR_TX_THRESH:
            tx_thresh_reg <= wr_bits[11:0] |
                             (tx_thresh_reg & ~wr_mask[11:0]);
          `ADDR_EVT_MASK:
            evt_mask_reg <= wr_bits[`EVT_W-1:0] |
                            (evt_mask_reg & ~{`EVT_W{I_WSTRB[0]}});
          default:
            ;
        endcase
      end
      else if (bvalid_reg && I_BREADY)
        bvalid_reg <= 1'b0;
      // A new event wins over a write-one-to-clear in the same cycle
      evt_status_reg <= (evt_status_reg &
                         ~((wr_go && waddr == `ADDR_EVT_STATUS) ?
                           wr_bits[`EVT_W-1:0] : {`EVT_W{1'b0}})) | evt;
      // A set mask bit keeps its event off the interrupt line
      irq_reg <= |(evt_status_reg & ~evt_mask_reg);
      for (i = 0; i < 4; i = i + 1)
        case (line_src_reg[i])
          `SRC_ACQ_WAIT:   line_out_reg[i] <= acq_wait;
          `SRC_EXP_ACTIVE: line_out_reg[i] <= frame_state_reg == F_EXPOSE;
          `SRC_TX_ACTIVE:  line_out_reg[i] <= tx_busy_reg;
          default:         line_out_reg[i] <= 1'b0;
        endcase
    end
  end

  always @(posedge I_CORE_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= `RESP_OKAY;
    end
    else
    begin
      arready_reg <= I_ARVALID && !arready_reg && !rvalid_reg;
      if (arready_reg)
      begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= mapped(I_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
        case (raddr)
          `ADDR_CTRL:        rdata_reg <= {29'h0, ctrl_reg};
          `ADDR_LINE_SEL:    rdata_reg <= {30'h0, line_sel_reg};
          `ADDR_LINE_SRC:    rdata_reg <= {30'h0, line_src_reg[line_sel_reg]};
          `ADDR_DEBOUNCE:    rdata_reg <= {16'h0, deb_time_reg};
          `ADDR_AOI_HEIGHT:  rdata_reg <= {20'h0, aoi_height_reg};
          `ADDR_TX_TIME:     rdata_reg <= {8'h0, tx_time_reg};
          `ADDR_EXPOSURE:    rdata_reg <= {8'h0, exposure_reg};
          `ADDR_FRAME_COUNT: rdata_reg <= {24'h0, frame_count_reg};
          `ADDR_TX_THRESH:   rdata_reg <= {20'h0, tx_thresh_reg};
          `ADDR_STATUS:
            rdata_reg <= {4'h0, lines_done_reg, 7'h0, avg_ready_reg,
                          tx_pend_reg, tx_busy_reg, frame_state_reg,
                          acq_state_reg};
          `ADDR_EVT_STATUS:  rdata_reg <= {27'h0, evt_status_reg};
          `ADDR_EVT_MASK:    rdata_reg <= {27'h0, evt_mask_reg};
          default:           rdata_reg <= 32'h0;
        endcase
      end
      else if (rvalid_reg && I_RREADY)
        rvalid_reg <= 1'b0;
    end
  end

  assign O_AWREADY         = awready_reg;
  assign O_WREADY          = awready_reg;
  assign O_BVALID          = bvalid_reg;
  assign O_BRESP           = bresp_reg;
  assign O_ARREADY         = arready_reg;
  assign O_RVALID          = rvalid_reg;
  assign O_RDATA           = rdata_reg;
  assign O_RRESP           = rresp_reg;
  assign O_OUTPUT_LINE     = line_out_reg;
  assign O_EXPOSURE_ACTIVE = frame_state_reg[2];
  assign O_READOUT_ACTIVE  = frame_state_reg[3];
  assign O_TX_ACTIVE       = tx_busy_reg;
  assign O_IRQ             = irq_reg;

endmodule // frame_acquisition_sequencer

// ===== tb/frame_acquisition_sequencer_props.sv
`timescale 1ns/1ns
module frame_acquisition_sequencer_props (
  input wire logic        I_CORE_CLK,
  input wire logic        I_NRST,
  input wire logic        I_NET_READY,
  input wire logic        I_BREADY,
  input wire logic        I_RREADY,
  input wire logic        O_AWREADY,
  input wire logic        O_WREADY,
  input wire logic        O_BVALID,
  input wire logic [1:0]  O_BRESP,
  input wire logic        O_ARREADY,
  input wire logic        O_RVALID,
  input wire logic [31:0] O_RDATA,
  input wire logic        O_EXPOSURE_ACTIVE,
  input wire logic        O_READOUT_ACTIVE,
  input wire logic        O_TX_ACTIVE
);
  logic [15:0] rd_cnt;
  logic [15:0] rd_len;
  logic [15:0] tx_len;
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);
  // Readout length is kept after the fall, tx is compared against it
  always @(posedge I_CORE_CLK or negedge I_NRST)
    if (!I_NRST)
    begin
      rd_cnt <= 16'h0;
      rd_len <= 16'h0;
      tx_len <= 16'h0;
    end
    else
    begin
      rd_cnt <= O_READOUT_ACTIVE ? rd_cnt + 16'h1 : 16'h0;
      tx_len <= O_TX_ACTIVE ? tx_len + 16'h1 : 16'h0;
      if ($fell(O_READOUT_ACTIVE))
        rd_len <= rd_cnt;
    end
  chk_ready_pair: assert property (O_AWREADY == O_WREADY)
    else $error("write readies differ");
  chk_write_answer: assert property (O_AWREADY |=> O_BVALID && !O_AWREADY)
    else $error("write answer late");
  chk_bresp_hold: assert property (O_BVALID && !I_BREADY |=>
    O_BVALID && $stable(O_BRESP)) else $error("write answer dropped");
  chk_read_answer: assert property (O_ARREADY |=> O_RVALID && !O_ARREADY)
    else $error("read answer late");
  chk_rdata_hold: assert property (O_RVALID && !I_RREADY |=>
    O_RVALID && $stable(O_RDATA)) else $error("read answer dropped");
  chk_readout_follows: assert property ($fell(O_EXPOSURE_ACTIVE) |->
    ##[0:1] O_READOUT_ACTIVE) else $error("no readout after exposure");
  chk_phase_exclusive: assert property (!(O_EXPOSURE_ACTIVE &&
    O_READOUT_ACTIVE)) else $error("exposure overlaps readout");
  chk_tx_net_ready: assert property ($rose(O_TX_ACTIVE) |->
    $past(I_NET_READY)) else $error("tx without network");
  chk_tx_min_len: assert property ($fell(O_TX_ACTIVE) |->
    tx_len >= rd_len) else $error("tx shorter than readout");
  cover property ($rose(O_TX_ACTIVE));
  cover property ($fell(O_READOUT_ACTIVE));
  cover property (O_BVALID && O_BRESP == 2'b10);
endmodule // frame_acquisition_sequencer_props

bind frame_acquisition_sequencer frame_acquisition_sequencer_props chk_u (
  .I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_NET_READY(I_NET_READY),
  .I_BREADY(I_BREADY), .I_RREADY(I_RREADY), .O_AWREADY(O_AWREADY),
  .O_WREADY(O_WREADY), .O_BVALID(O_BVALID), .O_BRESP(O_BRESP),
  .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .O_RDATA(O_RDATA),
  .O_EXPOSURE_ACTIVE(O_EXPOSURE_ACTIVE),
  .O_READOUT_ACTIVE(O_READOUT_ACTIVE), .O_TX_ACTIVE(O_TX_ACTIVE));

// ===== tb/trigger_host_model.sv
`timescale 1ns/1ns
module trigger_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_fire,
  input  wire logic [7:0] i_width,
  input  wire logic       i_net_en,
  output logic            o_trig,
  output logic            o_net_ready
);
  logic [7:0] left_reg;
  // Pin idles low between pulses so every pulse gives a clean rising edge
  always @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
    begin
      o_trig <= 1'b0;
      left_reg <= 8'h0;
      o_net_ready <= 1'b0;
    end
    else
    begin
      o_net_ready <= i_net_en;
      if (i_fire)
        o_trig <= 1'b1;
      else if (left_reg == 8'h0)
        o_trig <= 1'b0;
      left_reg <= i_fire ? i_width - 8'h1 : left_reg - (left_reg != 8'h0);
    end
endmodule // trigger_host_model

// ===== tb/frame_acquisition_sequencer_tb_top.sv
`timescale 1ns/1ns
`include "acq_seq_map.vh"
module frame_acquisition_sequencer_tb_top;
  localparam int SD = 5;
  localparam int RDL = 4 * 2 + 4;
  logic clk = 0, nrst = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic fire = 0, net_en = 0;
  logic [7:0] awa = 0, ara = 0, width = 0;
  logic [31:0] wd = 0, rd;
  logic [1:0] rs;
  wire trig, net, awr, wr_rdy, bv, arr, rv, irq, ex, ro, tx;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [3:0] line;
  int failures = 0, checks = 0, cyc = 0;
  int rise [4], len [4], cnt [4], nfall [4];
  logic [3:0] s_q = 0;
  wire [3:0] s = {tx, ro, ex, trig};
  frame_acquisition_sequencer #(.START_DELAY_CYC(SD), .LINE_CYC(2),
    .OVERHEAD_CYC(4)) dut_u (.I_CORE_CLK(clk), .I_NRST(nrst),
    .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv),
    .O_WREADY(wr_rdy), .I_WDATA(wd), .I_WSTRB(4'hf), .O_BVALID(bv),
    .I_BREADY(bre), .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr),
    .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rre), .O_RDATA(rdat),
    .O_RRESP(rr), .I_EXT_TRIGGER_IN(trig), .I_NET_READY(net),
    .O_OUTPUT_LINE(line), .O_EXPOSURE_ACTIVE(ex), .O_READOUT_ACTIVE(ro),
    .O_TX_ACTIVE(tx), .O_IRQ(irq));
  trigger_host_model host_u (.i_clk(clk), .i_nrst(nrst), .i_fire(fire),
    .i_width(width), .i_net_en(net_en), .o_trig(trig), .o_net_ready(net));
  initial forever #25 clk = ~clk;
  task give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Rise time and length of pin, exposure, readout and tx, in cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    s_q <= s;
    for (int k = 0; k < 4; k++)
    begin
      if (s[k] && !s_q[k])
        rise[k] <= cyc;
      cnt[k] <= s[k] ? cnt[k] + 1 : 0;
      if (!s[k] && s_q[k])
        len[k] <= cnt[k];
      if (!s[k] && s_q[k])
        nfall[k] <= nfall[k] + 1;
    end
    if (cyc == 20000)
    begin
      failures++;
      give_verdict;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awv <= 1;
    wv <= 1;
    awa <= a;
    wd <= d;
    bre <= 1;
    do @(posedge clk); while (!awr);
    awv <= 0;
    wv <= 0;
    while (!bv) @(posedge clk);
    rs = br;
    bre <= 0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    arv <= 1;
    ara <= a;
    rre <= 1;
    do @(posedge clk); while (!arr);
    arv <= 0;
    while (!rv) @(posedge clk);
    rd = rdat;
    rs = rr;
    rre <= 0;
    check(rd, exp);
  endtask
  task wait_fall(input int k);
    int n0;
    n0 = nfall[k];
    while (nfall[k] == n0) @(posedge clk);
  endtask
  task pulse(input logic [7:0] w);
    @(posedge clk);
    fire <= 1;
    width <= w;
    @(posedge clk);
    fire <= 0;
  endtask
  task t_regs;
    rd_chk(`ADDR_AOI_HEIGHT, 32'h0f0);
    rd_chk(`ADDR_EXPOSURE, 32'hfa0);
    rd_chk(`ADDR_FRAME_COUNT, 32'h1);
    rd_chk(`ADDR_TX_THRESH, 32'h10);
    rd_chk(`ADDR_TX_TIME, 32'h0);
    rd_chk(`ADDR_STATUS, 32'h5);
    rd_chk(8'h3c, 32'h0);
    check(rs, `RESP_SLVERR);
    wr(8'h40, 32'h1);
    check(rs, `RESP_SLVERR);
    $display("t_regs done");
  endtask
  task t_lines;
    for (int k = 0; k < 4; k++)
    begin
      wr(`ADDR_LINE_SEL, k);
      wr(`ADDR_LINE_SRC, `SRC_ACQ_WAIT);
    end
    wr(`ADDR_LINE_SEL, 32'h2);
    wr(`ADDR_LINE_SRC, `SRC_LOW);
    repeat (2) @(posedge clk);
    check(line, 4'hb);
    wr(`ADDR_LINE_SRC, `SRC_ACQ_WAIT);
    repeat (2) @(posedge clk);
    check(line, 4'hf);
    rd_chk(`ADDR_LINE_SRC, `SRC_ACQ_WAIT);
    $display("t_lines done");
  endtask
  task t_legacy;
    int t0;
    wr(`ADDR_CTRL, 32'h1);
    wr(`ADDR_EXPOSURE, 32'd10);
    wr(`ADDR_AOI_HEIGHT, 32'd3);
    wr(`ADDR_TX_THRESH, 32'd1);
    net_en <= 1;
    pulse(3);
    while (!ex) @(posedge clk);
    t0 = rise[0];
    check(line, 4'h0);
    pulse(3);
    wait_fall(2);
    check(rise[1] - t0, 3 + SD);
    check(len[1], 10);
    check(rise[2] - rise[1], 10);
    check(len[2], RDL);
    wr(`ADDR_EVT_MASK, 32'h0);
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    rd_chk(`ADDR_EVT_STATUS, 32'h0f);
    wr(`ADDR_EVT_MASK, 32'h1f);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    wr(`ADDR_EVT_STATUS, 32'h1f);
    rd_chk(`ADDR_EVT_STATUS, 32'h0);
    // Transmission may already be over here, so wait on the level
    while (tx) @(posedge clk);
    check(len[3], RDL);
    check(line, 4'hf);
    $display("t_legacy done");
  endtask
  task t_debounce;
    wr(`ADDR_CTRL, 32'h5);
    wr(`ADDR_DEBOUNCE, 32'd4);
    pulse(2);
    // Short pulse must be filtered, so give it time to show up wrongly
    repeat (20) @(posedge clk);
    rd_chk(`ADDR_EVT_STATUS, 32'h0);
    pulse(12);
    wait_fall(3);
    check(rise[1] - rise[0], 3 + 4 + SD);
    wr(`ADDR_EVT_STATUS, 32'h1f);
    $display("t_debounce done");
  endtask
  task t_standard;
    wr(`ADDR_CTRL, 32'h0);
    wr(`ADDR_FRAME_COUNT, 32'd2);
    wr(`ADDR_TX_TIME, 32'd40);
    net_en <= 0;
    pulse(3);
    repeat (20) @(posedge clk);
    wr(`ADDR_CMD, 32'h1);
    rd_chk(`ADDR_EVT_STATUS, 32'h11);
    wr(`ADDR_EVT_STATUS, 32'h1f);
    check(line, 4'h0);
    pulse(3);
    wait_fall(2);
    repeat (4) @(posedge clk);
    check(tx, 1'b0);
    net_en <= 1;
    wait_fall(3);
    check(len[3], 40);
    wr(`ADDR_TX_TIME, 32'h0);
    pulse(3);
    wait_fall(3);
    check(len[3], RDL);
    repeat (4) @(posedge clk);
    check(line, 4'hf);
    rd_chk(`ADDR_EVT_STATUS, 32'h06);
    wr(`ADDR_EVT_STATUS, 32'h1f);
    $display("t_standard done");
  endtask
  task t_avg;
    wr(`ADDR_CTRL, 32'h2);
    wr(`ADDR_CMD, 32'h1);
    pulse(3);
    wait_fall(2);
    repeat (4) @(posedge clk);
    check(tx, 1'b0);
    pulse(3);
    wait_fall(3);
    repeat (4) @(posedge clk);
    check(line, 4'hf);
    $display("t_avg done");
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1;
    t_regs;
    t_lines;
    t_legacy;
    t_debounce;
    t_standard;
    t_avg;
    give_verdict;
  end
endmodule // frame_acquisition_sequencer_tb_top
